/* hw/pin_cycle_engine.sv */
module pin_cycle_engine #(
    parameter int SETUP_CYC  = prio_host_pkg::SETUP_CYC,
    parameter int STROBE_CYC = prio_host_pkg::STROBE_CYC,
    parameter int HOLD_CYC   = prio_host_pkg::HOLD_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       startRead,
    input  wire logic [2:0] startSel,
    input  wire logic [7:0] startData,
    output logic            busy,
    output logic            done,
    output logic [7:0]      readData,
    output logic            csN,
    output logic            rwOut,
    output logic [2:0]      selOut,
    output logic [7:0]      dbOut,
    output logic            dbOe,
    input  wire logic [7:0] dbIn
);

    if (SETUP_CYC < 1 || STROBE_CYC < 3 || HOLD_CYC < 1 ||
        SETUP_CYC > 255 || STROBE_CYC > 255 || HOLD_CYC > 255)
    begin : badTiming
        $error("pin_cycle_engine: timing counts out of range");
    end

    typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_e;
    phase_e     phase;
    logic [7:0] count;
    logic [7:0] dbMeta;
    logic [7:0] dbSync;
    logic       lastCycle;

    assign lastCycle = (count == 8'h00);

    // ------------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            phase <= PH_IDLE;
            count <= 8'h00;
        end
        else
        begin
            unique case (phase)
                PH_IDLE:
                if (start)
                begin
                    phase <= PH_SETUP;
                    count <= 8'(SETUP_CYC - 1);
                end
                PH_SETUP:
                if (lastCycle)
                begin
                    phase <= PH_STROBE;
                    count <= 8'(STROBE_CYC - 1);
                end
                else
                    count <= count - 8'h01;
                PH_STROBE:
                if (lastCycle)
                begin
                    phase <= PH_HOLD;
                    count <= 8'(HOLD_CYC - 1);
                end
                else
                    count <= count - 8'h01;
                PH_HOLD:
                if (lastCycle)
                    phase <= PH_IDLE;
                else
                    count <= count - 8'h01;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pins: select and direction settle before the strobe falls
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            csN   <= 1'b1;
            rwOut <= 1'b1;
            selOut <= 3'h0;
            dbOut <= 8'h00;
            dbOe  <= 1'b0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (phase == PH_IDLE && start)
            begin
                rwOut <= startRead; // R19
                selOut <= startSel;
                dbOut <= startData;
                dbOe  <= !startRead;
                busy  <= 1'b1;
            end
            if (phase == PH_SETUP && lastCycle)
                csN <= 1'b0; // R19
            if (phase == PH_STROBE && lastCycle)
                csN <= 1'b1;
            if (phase == PH_HOLD && lastCycle)
            begin
                dbOe <= 1'b0; // R21
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read capture through a two-stage synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dbMeta   <= 8'h00;
            dbSync   <= 8'h00;
            readData <= 8'h00;
        end
        else
        begin
            dbMeta <= dbIn;
            dbSync <= dbMeta;
            if (phase == PH_STROBE && lastCycle && rwOut)
                readData <= dbSync;
        end
    end

    rwStable_a: assert property (@(posedge clk_sys) disable iff (rst) // R20
        !csN && !$past(csN) |-> $stable(rwOut) && $stable(selOut))
        else $error("direction or select moved while strobe low");

    setupFirst_a: assert property (@(posedge clk_sys) disable iff (rst) // R19
        $fell(csN) |-> $past(busy) && $stable(rwOut) && $stable(selOut))
        else $error("strobe fell without settled select");

    strobeLen_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(csN) |-> (!csN)[*3]) // R19
        else $error("strobe low phase too short");

    readNoDrive_a: assert property (@(posedge clk_sys) disable iff (rst)
        !csN && rwOut |-> !dbOe) // R19
        else $error("data bus driven during a read");

    writeHold_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(csN) && !rwOut |-> dbOe && $stable(dbOut)) // R21
        else $error("write data not held at strobe rise");

endmodule // pin_cycle_engine

/* hw/prio_irq_host.sv */
// Summary of operation
// (R1) Device latches inputs zero to two on falls
// (R2) Device edge select chooses edge for three, four
// (R3) Device mask register enables latches with ones
// (R4) Masked latches still set by input edges
// (R5) Reading active register clears it and latches
// (R6) Read active register only to start service
// (R7) Without priority, first unmasked latch raises request
// (R8) Remaining latches restart sequence after the read
// (R9) With priority, only highest pending enters register
// (R10) Priority read pushes register onto five-deep stack
// (R11) Write to active register pops the stack
// (R12) Write active register when each service ends
// (R13) Lower pending interrupts wait for higher ones
// (R14) Higher interrupt nests immediately with new request
// (R15) Low reset pin clears all device registers
// (R16) Write port value before enabling outputs
// (R17) Clear port C latches after entering interrupt mode
// (R18) No port A reads or port B writes early
// (R19) Settle select and direction before chip select
// (R20) Direction line steady while chip select low
// (R21) Device takes write data as select rises
// (R22) Device ignores value written to active register
// (R23) Request output open drain, released by read
// (R24) Port C reads latches, zero bits clear them
// (R25) Mode bit turns port C into interrupt controller
module prio_irq_host (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [7:0]      regRdData,
    output logic            resetPinN,
    output logic            csN,
    output logic            rwOut,
    output logic [2:0]      selOut,
    output logic [7:0]      dbOut,
    output logic            dbOe,
    input  wire logic [7:0] dbIn,
    input  wire logic       irqPinN
);

    typedef enum {SQ_IDLE, SQ_RUN, SQ_QUIET} seq_e;
    typedef enum {KIND_SW, KIND_SVC, KIND_CLEAR} kind_e;

    seq_e       state;
    kind_e      kind;
    logic       engStart;
    logic       engRead;
    logic [2:0] engSel;
    logic [7:0] engData;
    logic       engBusy;
    logic       engDone;
    logic [7:0] engReadData;
    logic       irqMeta;
    logic       irqSync;
    logic       irqActive;
    logic [7:0] resetCount;
    logic [2:0] options;
    logic [7:0] wrData;
    logic [7:0] lastRead;
    logic [7:0] airCaptured;
    logic       newAir;
    logic [2:0] depth;
    logic [2:0] portWritten;
    logic       refused;
    logic       orderWarn;
    logic       clearPending;
    logic [7:0] quiet;
    logic       swReq;
    logic [2:0] swSel;
    logic       swRead;
    logic       guardHit;
    logic       swGo;
    logic       svcGo;
    logic       resetting;
    logic       airWrite;

    assign irqActive = !irqSync;
    assign resetting = !resetPinN;
    assign swReq     = regWr && regAddr == prio_host_pkg::OFF_CMD;
    assign swSel     = regWrData[prio_host_pkg::CMD_SEL_LSB +: 3];
    assign swRead    = regWrData[prio_host_pkg::CMD_READ_BIT];
    assign guardHit  = options[prio_host_pkg::OPT_GUARD] &&
        ((swSel == prio_host_pkg::SEL_PORT_A && swRead) ||
         (swSel == prio_host_pkg::SEL_PORT_B && !swRead)); // R18
    assign swGo      = swReq && state == SQ_IDLE && !clearPending &&
        !resetting && !guardHit;
    assign svcGo     = options[prio_host_pkg::OPT_AUTO_SVC] && irqActive &&
        depth < prio_host_pkg::STACK_DEPTH; // R6
    assign airWrite  = engDone && !engRead &&
        engSel == prio_host_pkg::SEL_AIR;

    // ------------------------------------------------------------------
    // Request line synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irqMeta <= 1'b1;
            irqSync <= 1'b1;
        end
        else
        begin
            irqMeta <= irqPinN;
            irqSync <= irqMeta;
        end
    end

    // ------------------------------------------------------------------
    // Device reset pulse, also issued at power-up
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            resetPinN  <= 1'b0;
            resetCount <= prio_host_pkg::RESET_CYC - 8'h01;
        end
        else if (regWr && regAddr == prio_host_pkg::OFF_RESET)
        begin
            resetPinN  <= 1'b0; // R15
            resetCount <= prio_host_pkg::RESET_CYC - 8'h01;
        end
        else if (resetting)
        begin
            if (resetCount == 8'h00)
                resetPinN <= 1'b1;
            else
                resetCount <= resetCount - 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state    <= SQ_IDLE;
            kind     <= KIND_SW;
            engStart <= 1'b0;
            engRead  <= 1'b1;
            engSel   <= 3'h0;
            engData  <= 8'h00;
            quiet    <= 8'h00;
        end
        else
        begin
            engStart <= 1'b0;
            unique case (state)
                SQ_IDLE:
                if (!resetting)
                begin
                    if (clearPending)
                    begin
                        engStart <= 1'b1; // R17
                        engRead  <= 1'b0;
                        engSel   <= prio_host_pkg::SEL_PORT_C;
                        engData  <= 8'h00;
                        kind     <= KIND_CLEAR;
                        state    <= SQ_RUN;
                    end
                    else if (swGo)
                    begin
                        engStart <= 1'b1;
                        engRead  <= swRead;
                        engSel   <= swSel;
                        engData  <= wrData;
                        kind     <= KIND_SW;
                        state    <= SQ_RUN;
                    end
                    else if (svcGo)
                    begin
                        engStart <= 1'b1; // R6
                        engRead  <= 1'b1;
                        engSel   <= prio_host_pkg::SEL_AIR;
                        kind     <= KIND_SVC;
                        state    <= SQ_RUN;
                    end
                end
                SQ_RUN:
                if (engDone)
                begin
                    state <= SQ_QUIET;
                    quiet <= prio_host_pkg::QUIET_CYC;
                end
                SQ_QUIET:
                if (quiet == 8'h00)
                    state <= SQ_IDLE;
                else
                    quiet <= quiet - 8'h01;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Completion effects: stack depth, captures, follow-up clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            depth        <= 3'h0;
            lastRead     <= 8'h00;
            airCaptured  <= 8'h00;
            clearPending <= 1'b0;
            portWritten  <= 3'h0;
        end
        else if (resetting)
        begin
            depth        <= 3'h0;
            clearPending <= 1'b0;
            portWritten  <= 3'h0;
        end
        else
        begin
            if (engDone && engRead && engSel == prio_host_pkg::SEL_AIR &&
                depth < prio_host_pkg::STACK_DEPTH)
                depth <= depth + 3'h1; // R6
            else if (airWrite && depth != 3'h0)
                depth <= depth - 3'h1; // R12
            if (engDone && engRead && kind == KIND_SW)
                lastRead <= engReadData;
            if (engDone && kind == KIND_SVC)
                airCaptured <= engReadData;
            if (engDone && !engRead && engSel == prio_host_pkg::SEL_CTRL &&
                engData[prio_host_pkg::CR_MODE_BIT] &&
                options[prio_host_pkg::OPT_AUTO_CLEAR])
                clearPending <= 1'b1; // R17
            else if (state == SQ_IDLE && clearPending)
                clearPending <= 1'b0;
            if (engDone && !engRead && engSel <= prio_host_pkg::SEL_PORT_C)
                portWritten[engSel[1:0]] <= 1'b1; // R16
        end
    end

    // ------------------------------------------------------------------
    // Register port: writes, sticky flags and read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            options   <= prio_host_pkg::OPT_RESET;
            wrData    <= 8'h00;
            refused   <= 1'b0;
            orderWarn <= 1'b0;
            newAir    <= 1'b0;
        end
        else
        begin
            if (regWr && regAddr == prio_host_pkg::OFF_OPTIONS)
                options <= regWrData[2:0];
            if (regWr && regAddr == prio_host_pkg::OFF_WDATA)
                wrData <= regWrData;
            if (swReq && !swGo)
                refused <= 1'b1;
            else if (regWr && regAddr == prio_host_pkg::OFF_STATUS &&
                     regWrData[prio_host_pkg::ST_REFUSED])
                refused <= 1'b0;
            if (swGo && !swRead && swSel >= prio_host_pkg::SEL_DIR_A &&
                swSel <= prio_host_pkg::SEL_MASK && wrData != 8'h00 &&
                !portWritten[2'(swSel - prio_host_pkg::SEL_DIR_A)])
                orderWarn <= 1'b1; // R16
            else if (regWr && regAddr == prio_host_pkg::OFF_STATUS &&
                     regWrData[prio_host_pkg::ST_WARN])
                orderWarn <= 1'b0;
            if (engDone && kind == KIND_SVC)
                newAir <= 1'b1;
            else if (regRd && regAddr == prio_host_pkg::OFF_AIRVAL)
                newAir <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            regRdData <= 8'h00;
        else if (regRd)
        begin
            unique case (regAddr)
                prio_host_pkg::OFF_WDATA:   regRdData <= wrData;
                prio_host_pkg::OFF_STATUS:
                    regRdData <= {depth, orderWarn, refused, resetting,
                                  irqActive,
                                  state != SQ_IDLE || clearPending};
                prio_host_pkg::OFF_RDATA:   regRdData <= lastRead;
                prio_host_pkg::OFF_OPTIONS: regRdData <= {5'h00, options};
                prio_host_pkg::OFF_AIRVAL:
                    regRdData <= {newAir, airCaptured[6:0]};
                default:                    regRdData <= 8'h00;
            endcase
        end
        else
            regRdData <= 8'h00;
    end

    // ------------------------------------------------------------------
    // Pin cycle engine
    // ------------------------------------------------------------------
    pin_cycle_engine engine (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .start     (engStart),
        .startRead (engRead),
        .startSel  (engSel),
        .startData (engData),
        .busy      (engBusy),
        .done      (engDone),
        .readData  (engReadData),
        .csN       (csN),
        .rwOut     (rwOut),
        .selOut    (selOut),
        .dbOut     (dbOut),
        .dbOe      (dbOe),
        .dbIn      (dbIn)
    );

    svcOnIrq_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
        engStart && kind == KIND_SVC |-> $past(irqActive) &&
        $past(depth) < prio_host_pkg::STACK_DEPTH)
        else $error("service read without pending request");

    airWriteDepth_a: assert property (@(posedge clk_sys) disable iff (rst)
        engStart && !engRead && engSel == prio_host_pkg::SEL_AIR && // R12
        kind == KIND_SW |=> engBusy)
        else $error("service-complete write not launched");

    modeClear_a: assert property (@(posedge clk_sys) disable iff (rst)
        engDone && !engRead && engSel == prio_host_pkg::SEL_CTRL && // R17
        engData[0] && options[1] && !resetting
        |-> ##[1:12] engStart && engSel == prio_host_pkg::SEL_PORT_C &&
        engData == 8'h00 && !engRead)
        else $error("latch clear did not follow mode entry");

    guardBlock_a: assert property (@(posedge clk_sys) disable iff (rst)
        swReq && guardHit |=> !(engStart && kind == KIND_SW) && refused) // R18
        else $error("guarded port access was launched");

    resetPulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(resetPinN) |-> (!resetPinN)[*8] ##1 csN) // R15
        else $error("device reset pulse too short");

    depthTrack_a: assert property (@(posedge clk_sys) disable iff (rst)
        airWrite && !resetting && $past(depth) != 3'h0 && depth != 3'h0
        |=> depth == $past(depth) - 3'h1) // R12
        else $error("stack depth not popped by write");

endmodule // prio_irq_host

/* shared/prio_host_pkg.sv */
package prio_host_pkg;

    // ------------------------------------------------------------------
    // Clock and pin timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int T_SETUP_NS     = 40;
    localparam int T_STROBE_NS    = 300;
    localparam int T_HOLD_NS      = 40;
    localparam int T_RESET_NS     = 2000;
    localparam int T_QUIET_NS     = 40;
    // Least times round up to whole cycles
    localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] RESET_CYC =
        8'((T_RESET_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] QUIET_CYC =
        8'((T_QUIET_NS * CLK_MHZ + 999) / 1000);

    // ------------------------------------------------------------------
    // Device register select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_PORT_A = 3'h0;
    localparam logic [2:0] SEL_PORT_B = 3'h1;
    localparam logic [2:0] SEL_PORT_C = 3'h2;
    localparam logic [2:0] SEL_DIR_A  = 3'h3;
    localparam logic [2:0] SEL_MASK   = 3'h5;
    localparam logic [2:0] SEL_CTRL   = 3'h6;
    localparam logic [2:0] SEL_AIR    = 3'h7;
    localparam int         CR_MODE_BIT = 0;
    localparam int         CR_PRIO_BIT = 1;
    localparam logic [2:0] STACK_DEPTH = 3'h5;

    // ------------------------------------------------------------------
    // Controller's own registers
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_CMD     = 4'h0;
    localparam logic [3:0] OFF_WDATA   = 4'h1;
    localparam logic [3:0] OFF_STATUS  = 4'h2;
    localparam logic [3:0] OFF_RDATA   = 4'h3;
    localparam logic [3:0] OFF_RESET   = 4'h4;
    localparam logic [3:0] OFF_OPTIONS = 4'h5;
    localparam logic [3:0] OFF_AIRVAL  = 4'h6;
    localparam int CMD_SEL_LSB  = 0;
    localparam int CMD_READ_BIT = 3;
    localparam int OPT_AUTO_SVC   = 0;
    localparam int OPT_AUTO_CLEAR = 1;
    localparam int OPT_GUARD      = 2;
    localparam logic [2:0] OPT_RESET = 3'h6;
    localparam int ST_BUSY      = 0;
    localparam int ST_IRQ       = 1;
    localparam int ST_RESETTING = 2;
    localparam int ST_REFUSED   = 3;
    localparam int ST_WARN      = 4;
    localparam int ST_DEPTH_LSB = 5;

endpackage

/* verification/prio_device_model.sv */
module prio_device_model (
    input  wire logic       resetPinN,
    input  wire logic       csN,
    input  wire logic       rwOut,
    input  wire logic [2:0] selOut,
    input  wire logic [7:0] dbOut,
    input  wire logic [4:0] irqIn,
    output logic      [7:0] busOut,
    output wire             irqPinN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cr, mask;
    logic [4:0] latch, active_interrupt, fall, rise, stk [0:4];
    logic [4:0] prev = 5'h1f;
    int         sp;
    function automatic int hi(logic [4:0] v);
        hi = 0;
        for (int i = 0; i < 5; i++)
            if (v[i])
                hi = i + 1;
    endfunction
    // ------------------------------------------------------------------
    // Active register update after each strobe rise and each input change in interrupt mode
    // ------------------------------------------------------------------
    task automatic eval();
        logic [4:0] p;
        p = latch & mask[4:0] & {5{cr[0]}};
        if (!cr[1])
        begin
            if (active_interrupt == 5'h00)
                active_interrupt = p;
        end
        else if (hi(p) > hi(active_interrupt) && hi(p) > hi(sp > 0 ? stk[sp-1] : 5'h00))
            active_interrupt = 5'h01 << (hi(p) - 1);
    endtask
    assign irqPinN = (active_interrupt != 5'h00) ? 1'b0 : 1'bz;
    always @(negedge resetPinN)
    begin
        {cr, mask, busOut} = 24'h000000;
        {latch, active_interrupt} = 10'h000;
        sp = 0;
    end
    always @(irqIn)
    begin
        fall = prev & ~irqIn;
        rise = ~prev & irqIn;
        if (cr[0])
        begin
            latch = latch | (fall & 5'h07);
            latch[3] |= cr[2] ? fall[3] : rise[3];
            latch[4] |= cr[3] ? fall[4] : rise[4];
            eval();
        end
        prev = irqIn;
    end
    always @(negedge csN)
        if (rwOut)
            case (selOut)
                3'h2: busOut = {2'b00, active_interrupt == 5'h00, latch};
                3'h5: busOut = mask;
                3'h6: busOut = cr;
                3'h7: busOut = {3'h0, active_interrupt};
                default: busOut = 8'h00;
            endcase
    always @(posedge csN)
    begin
        busOut = ~busOut;
        if (resetPinN && rwOut && selOut == 3'h7)
        begin
            latch = latch & ~active_interrupt;
            if (cr[1] && sp < 5)
            begin
                stk[sp] = active_interrupt;
                sp++;
            end
            active_interrupt = 5'h00;
        end
        else if (resetPinN && !rwOut)
            case (selOut)
                3'h2: latch = cr[0] ? latch & dbOut[4:0] : latch;
                3'h5: mask = dbOut;
                3'h6: cr = dbOut;
                3'h7: {active_interrupt, sp} = {5'h00, sp > 0 ? sp - 1 : 0};
                default: ;
            endcase
        eval();
    end
endmodule // prio_device_model

/* verification/tb_prio_irq_host.sv */
module tb_prio_irq_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData, dbOut, devBus, q, s;
    logic [4:0] irqIn = 5'h1f;
    logic [2:0] selOut;
    logic       resetPinN, csN, rwOut, dbOe;
    wire        irqPinN;
    wire  [7:0] dbIn = dbOe ? dbOut : devBus;
    int         errorCnt, totalChecks, cycles;
    pullup (irqPinN);
    prio_irq_host dut (.clk_sys, .rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .resetPinN, .csN, .rwOut, .selOut, .dbOut, .dbOe, .dbIn,
        .irqPinN);
    prio_device_model farEnd (.resetPinN, .csN, .rwOut, .selOut, .dbOut,
        .irqIn, .busOut(devBus), .irqPinN);
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errorCnt++;
            completeRun();
        end
    end
    // ------------------------------------------------------------------
    // Bus tasks and scenarios
    // ------------------------------------------------------------------
    task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic dev(logic [2:0] sel, logic r, logic [7:0] d);
        wr(4'h1, d);
        wr(4'h0, {4'h0, r, sel});
        repeat (3) @(posedge clk_sys);
        s = 8'h01;
        for (int i = 0; i < 100 && s[0]; i++)
            rd(4'h2, s);
        chk("busy", s & 8'h01, 8'h00);
        repeat (8) @(posedge clk_sys);
        rd(4'h3, q);
    endtask
    task automatic pulse(int b);
        irqIn[b] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        irqIn[b] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(4'h2, s);
    endtask
    task automatic tReset();
        rd(4'h5, q);
        chk("options", q, 8'h06);
        rd(4'hf, q);
        chk("unmapped", q, 8'h00);
        wr(4'h0, 8'h08);
        rd(4'h2, s);
        chk("refused", s & 8'h0c, 8'h0c);
        for (int i = 0; i < 300 && s[2]; i++)
            rd(4'h2, s);
        wr(4'h2, 8'h08);
        rd(4'h2, s);
        chk("cleared", s & 8'h0c, 8'h00);
        wr(4'h5, 8'h02);
        $display("reset test done");
    endtask
    task automatic tMask();
        dev(3'h6, 1'b0, 8'h01);
        dev(3'h2, 1'b0, 8'h00);
        dev(3'h5, 1'b0, 8'h1e);
        dev(3'h5, 1'b1, 8'h00);
        chk("mask", q, 8'h1e);
        pulse(0);
        chk("masked irq", s & 8'h02, 8'h00);
        dev(3'h2, 1'b1, 8'h00);
        chk("latches", q, 8'h21);
        $display("mask test done");
    endtask
    task automatic tPlain();
        pulse(1);
        chk("irq", s & 8'h02, 8'h02);
        pulse(2);
        dev(3'h7, 1'b1, 8'h00);
        chk("first", q, 8'h02);
        dev(3'h7, 1'b1, 8'h00);
        chk("restart", q, 8'h04);
        dev(3'h2, 1'b1, 8'h00);
        chk("left", q, 8'h21);
        pulse(3);
        dev(3'h7, 1'b1, 8'h00);
        chk("rise", q, 8'h08);
        dev(3'h6, 1'b0, 8'h09);
        pulse(4);
        dev(3'h7, 1'b1, 8'h00);
        chk("fall", q, 8'h10);
        $display("plain test done");
    endtask
    task automatic tPrio();
        dev(3'h6, 1'b0, 8'h03);
        dev(3'h2, 1'b0, 8'h00);
        dev(3'h5, 1'b0, 8'h1f);
        pulse(1);
        dev(3'h7, 1'b1, 8'h00);
        chk("one", q, 8'h02);
        pulse(0);
        chk("held", s & 8'h02, 8'h00);
        pulse(2);
        chk("nest", s & 8'h02, 8'h02);
        dev(3'h7, 1'b1, 8'h00);
        chk("two", q, 8'h04);
        dev(3'h7, 1'b0, 8'h5a);
        rd(4'h2, s);
        chk("still", s & 8'h02, 8'h00);
        dev(3'h7, 1'b0, 8'h00);
        dev(3'h7, 1'b1, 8'h00);
        chk("low", q, 8'h01);
        $display("priority test done");
    endtask
    task automatic completeRun();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        tReset();
        tMask();
        tPlain();
        tPrio();
        completeRun();
    end
endmodule // tb_prio_irq_host
